//--- bench/pfsel_properties.sv
`timescale 1ns/10ps
// ----------------------------------------
// Bus and routing checks at the top ports
// ----------------------------------------
module pfsel_properties (
  input wire logic          I_CLK,      // System clock
  input wire logic          I_SYS_RST,  // Sync reset, high
  input wire logic [11:0]   I_ADDR,     // Byte address
  input wire logic [31:0]   I_WDATA,    // Write data
  input wire logic          I_WR,       // Write strobe
  input wire logic          I_RD,       // Read strobe
  input wire logic [31:0]   O_RDATA,    // Read data
  input wire logic [279:0]  O_PIN_SEL,  // Pin codes
  input wire logic [1119:0] I_FUNC_OUT, // Function outputs
  input wire logic [1119:0] I_FUNC_OE,  // Function enables
  input wire logic [69:0]   I_PIN_IN,   // Pad levels
  input wire logic [69:0]   O_PIN_OUT,  // Pad outputs
  input wire logic [69:0]   O_PIN_OE,   // Pad enables
  input wire logic [1119:0] O_FUNC_IN   // Routed pad levels
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // Routing is flopped, so expectations are kept one cycle
  logic        q_live; // Previous edge was out of reset
  logic        q_out0; // Selected output of pin A0
  logic        q_oe69; // Selected enable of pin E7
  logic [15:0] q_in0;  // Expected routed level of pin A0
  always @(posedge I_CLK) begin
    q_live <= !I_SYS_RST;
    q_out0 <= I_FUNC_OUT[O_PIN_SEL[3:0]];
    q_oe69 <= I_FUNC_OE[1104 + O_PIN_SEL[279:276]];
    q_in0  <= (16'h0001 << O_PIN_SEL[3:0]) & {16{I_PIN_IN[0]}};
  end
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
    else $error("read data not zero outside a read");
  a_read_pa_low: assert property (I_RD && I_ADDR == 12'h070
    |=> O_RDATA == $past(O_PIN_SEL[31:0])) else $error("port A low read wrong");
  a_pb_high_resv: assert property (I_RD && I_ADDR == 12'h07C
    |=> O_RDATA == {8'h00, $past(O_PIN_SEL[119:96])}) else $error("port B high read wrong");
  a_write_pb_low: assert property (I_WR && I_ADDR == 12'h078
    |=> O_PIN_SEL[95:64] == $past(I_WDATA)) else $error("port B low write lost");
  a_write_pc_high: assert property (I_WR && I_ADDR == 12'h084
    |=> O_PIN_SEL[183:152] == $past(I_WDATA)) else $error("port C high write lost");
  a_unmapped_read: assert property (I_RD && (I_ADDR < 12'h070 || I_ADDR > 12'h090
    || I_ADDR[1:0] != 2'b00) |=> O_RDATA == 32'h0) else $error("unmapped read not zero");
  a_sel_hold: assert property (!I_WR |=> $stable(O_PIN_SEL))
    else $error("pin codes moved without a write");
  a_route_out0: assert property (q_live |-> O_PIN_OUT[0] == q_out0)
    else $error("pin A0 output not from selected function");
  a_route_oe69: assert property (q_live |-> O_PIN_OE[69] == q_oe69)
    else $error("pin E7 enable not from selected function");
  a_route_in0: assert property (q_live |-> O_FUNC_IN[15:0] == q_in0)
    else $error("pin A0 level routed to wrong function");
endmodule // pfsel_properties

bind pfsel_top pfsel_properties pfsel_properties_i (
  .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_PIN_SEL(O_PIN_SEL),
  .I_FUNC_OUT(I_FUNC_OUT), .I_FUNC_OE(I_FUNC_OE), .I_PIN_IN(I_PIN_IN),
  .O_PIN_OUT(O_PIN_OUT), .O_PIN_OE(O_PIN_OE), .O_FUNC_IN(O_FUNC_IN)
);

//--- bench/tb_port_pin_function_select.sv
`timescale 1ns/10ps
module tb_port_pin_function_select;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic          clk = 1'b0;                  // System clock
  logic          rst = 1'b1;                  // Sync reset
  logic [11:0]   addr = 12'h000;              // Bus address
  logic [31:0]   wdata = 32'h0;               // Write data
  logic          wr = 1'b0;                   // Write strobe
  logic          rd = 1'b0;                   // Read strobe
  logic [1119:0] func_out = {70{16'h3C5A}};   // Function outputs
  logic [1119:0] func_oe = {70{16'hA5C3}};    // Function enables
  logic [69:0]   pin_in = 70'h0;              // Pad levels
  wire  [31:0]   rdata;                       // Read data
  wire  [279:0]  pin_sel;                     // Pin codes
  wire  [69:0]   pin_out;                     // Pad outputs
  wire  [69:0]   pin_oe;                      // Pad enables
  wire  [1119:0] func_in;                     // Routed levels
  int            bad_count = 0;               // Mismatches
  int            n_tests = 0;                 // Comparisons
  int            cycles = 0;                  // Hang guard
  always #4 clk = ~clk;
  // All-ones float value shows that only pins 2-6 take it
  pfsel_top #(.PA_LOW_FLOAT(32'hFFFFFFFF)) pfsel_top_i (
    .I_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .O_PIN_SEL(pin_sel), .I_FUNC_OUT(func_out),
    .I_FUNC_OE(func_oe), .I_PIN_IN(pin_in), .O_PIN_OUT(pin_out),
    .O_PIN_OE(pin_oe), .O_FUNC_IN(func_in)
  );
  // ----------------------------------------
  // Compare, bus and expectation helpers
  // ----------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bits(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] ofs(input logic [3:0] i);
    ofs = 12'h070 + {6'h00, i, 2'b00};
  endfunction
  function automatic logic [31:0] pat(input logic [3:0] i);
    pat = 32'h9E3779B9 ^ {8{i}};
  endfunction
  // Port B high keeps only its low three bytes
  function automatic logic [31:0] exp_val(input logic [3:0] i, input bit written);
    if (!written) exp_val = (i == 4'h0) ? 32'h0FFFFF00 : 32'h00000000;
    else exp_val = (i == 4'h3) ? (pat(i) & 32'h00FFFFFF) : pat(i);
  endfunction
  task automatic wr_word(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdata <= d;
  endtask
  task automatic idle;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Read data is looked at only in the cycle after the strobe
  task automatic rd_word(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    wr <= 1'b0;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk_word(rdata, exp);
  endtask
  task automatic read_all(input bit written);
    for (int i = 0; i < 9; i++) rd_word(ofs(i[3:0]), exp_val(i[3:0], written));
  endtask
  task automatic do_reset(input int n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (n - 1) @(posedge clk);
    rst <= 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_walk;
    for (int i = 0; i < 9; i++) wr_word(ofs(i[3:0]), pat(i[3:0]));
    read_all(1'b1);
  endtask
  // Nibble n of the pattern written to word i
  function automatic logic [3:0] nib(input logic [3:0] i, input int n);
    logic [31:0] w;
    w = pat(i) >> (4 * n);
    nib = w[3:0];
  endfunction
  task automatic t_fields;
    chk_bits({12'h0, pin_sel[3:0]}, {12'h0, nib(4'h0, 0)});
    chk_bits({12'h0, pin_sel[31:28]}, {12'h0, nib(4'h0, 7)});
    chk_bits({12'h0, pin_sel[35:32]}, {12'h0, nib(4'h1, 0)});
    chk_bits({12'h0, pin_sel[63:60]}, {12'h0, nib(4'h1, 7)});
    chk_bits({12'h0, pin_sel[119:116]}, {12'h0, nib(4'h3, 5)});
    chk_bits({12'h0, pin_sel[183:180]}, {12'h0, nib(4'h5, 7)});
    chk_bits({12'h0, pin_sel[247:244]}, {12'h0, nib(4'h7, 7)});
    chk_bits({12'h0, pin_sel[279:276]}, {12'h0, nib(4'h8, 7)});
  endtask
  task automatic t_unmapped;
    wr_word(12'h094, 32'hFFFFFFFF);
    wr_word(12'h06C, 32'hFFFFFFFF);
    wr_word(12'h870, 32'hFFFFFFFF);
    rd_word(12'h094, 32'h0);
    rd_word(12'h06C, 32'h0);
    rd_word(12'h870, 32'h0);
    rd_word(12'h071, 32'h0);
    read_all(1'b1);
  endtask
  task automatic t_route;
    for (int k = 0; k < 16; k++) begin
      wr_word(12'h070, {28'h0, k[3:0]});
      func_out[15:0] <= 16'h0001 << k;
      func_oe[15:0] <= ~(16'h0001 << k);
      pin_in[0] <= k[0];
      idle;
      @(posedge clk);
      #1 chk_bits({15'h0, pin_out[0]}, 16'h0001);
      chk_bits({15'h0, pin_oe[0]}, 16'h0000);
      chk_bits(func_in[15:0], k[0] ? (16'h0001 << k) : 16'h0000);
    end
  endtask
  task automatic t_rereset;
    do_reset(2);
    read_all(1'b0);
  endtask
  // ----------------------------------------
  // Verdict, hang guard and main sequence
  // ----------------------------------------
  task automatic give_verdict;
    $display("Counts: %0d compared, %0d mismatched", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict;
    end
  end
  initial begin
    do_reset(10);
    read_all(1'b0);
    t_walk;
    t_fields;
    t_unmapped;
    t_route;
    t_rereset;
    give_verdict;
  end
endmodule // tb_port_pin_function_select

//--- hw/pfsel_defines.vh
`ifndef PFSEL_DEFINES_VH
`define PFSEL_DEFINES_VH

// ----------------------------------------------------------------------
// Register bus geometry
// ----------------------------------------------------------------------
`define PFSEL_AW          12
`define PFSEL_DW          32
`define PFSEL_RD_IDLE     32'h00000000

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PFSEL_OFS_PA_LOW  12'h070
`define PFSEL_OFS_PA_HIGH 12'h074
`define PFSEL_OFS_PB_LOW  12'h078
`define PFSEL_OFS_PB_HIGH 12'h07C
`define PFSEL_OFS_PC_LOW  12'h080
`define PFSEL_OFS_PC_HIGH 12'h084
`define PFSEL_OFS_PD_LOW  12'h088
`define PFSEL_OFS_PD_HIGH 12'h08C
`define PFSEL_OFS_PE_LOW  12'h090

// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define PFSEL_FW          4
`define PFSEL_NFUNC       16
`define PFSEL_NPIN        70
`define PFSEL_NREG        9
`define PFSEL_FIELDS_REG  8
`define PFSEL_PB_HIGH_W   24

// ----------------------------------------------------------------------
// Implemented bits and reset values
// ----------------------------------------------------------------------
`define PFSEL_MASK_FULL   32'hFFFFFFFF
`define PFSEL_MASK_PB_HI  32'h00FFFFFF
`define PFSEL_RST_ZERO    32'h00000000
`define PFSEL_PA_LOW_FIX  32'hF00000FF
`define PFSEL_PA_LOW_FLT  32'h00000000

`endif

//--- hw/pfsel_pin_route.v
`timescale 1ns/10ps
`include "pfsel_defines.vh"

// Steers one pin between its sixteen candidate functions
module pfsel_pin_route (
  input  wire                      i_clk,      // System clock
  input  wire                      i_rst,      // Synchronous reset, high
  input  wire [`PFSEL_FW-1:0]      i_sel,      // Function code of this pin
  input  wire [`PFSEL_NFUNC-1:0]   i_func_out, // Output of each function
  input  wire [`PFSEL_NFUNC-1:0]   i_func_oe,  // Output enable of each function
  input  wire                      i_pin_in,   // Level seen on the pin
  output reg                       o_pin_out,  // Level driven to the pad
  output reg                       o_pin_oe,   // Pad drive enable
  output reg  [`PFSEL_NFUNC-1:0]   o_func_in   // Pin level per function
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Code to one-hot; only the chosen function sees the pin
  function [`PFSEL_NFUNC-1:0] pfsel_onehot;
    input [`PFSEL_FW-1:0] code;
    begin
      pfsel_onehot = {{(`PFSEL_NFUNC-1){1'b0}}, 1'b1} << code;
    end
  endfunction

  wire [`PFSEL_NFUNC-1:0] pick = pfsel_onehot(i_sel); // Selected function

  // ----------------------------------------------------------------------
  // Registered routing
  // ----------------------------------------------------------------------
  // Unselected functions read zero so they never see stray edges
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_pin_out <= 1'b0;
      o_pin_oe  <= 1'b0;
      o_func_in <= {`PFSEL_NFUNC{1'b0}};
    end else begin
      o_pin_out <= |(pick & i_func_out);
      o_pin_oe  <= |(pick & i_func_oe);
      o_func_in <= pick & {`PFSEL_NFUNC{i_pin_in}};
    end
  end

endmodule // pfsel_pin_route

//--- hw/pfsel_sel_reg.v
`timescale 1ns/10ps
`include "pfsel_defines.vh"

// One selection word; bits outside the mask are held at zero
module pfsel_sel_reg #(
  parameter [31:0] RESET_VAL = `PFSEL_RST_ZERO, // Value after reset
  parameter [31:0] IMPL_MASK = `PFSEL_MASK_FULL  // Implemented bits
) (
  input  wire        i_clk,   // System clock
  input  wire        i_rst,   // Synchronous reset, high
  input  wire        i_we,    // Write strobe for this word
  input  wire [31:0] i_wdata, // Write data
  output reg  [31:0] o_value  // Stored selection word
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Masking on write keeps reserved bits reading zero
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_value <= RESET_VAL & IMPL_MASK;
    end else if (i_we) begin
      o_value <= i_wdata & IMPL_MASK;
    end
  end

endmodule // pfsel_sel_reg

//--- hw/pfsel_top.v
// Contract
// - Four-bit field per pin, pin n at 4n
// - Low word pins 0-7, high 8-15
// - Port B high holds pins 8-13 only
// - All words read/write, reset to zero except port A low pins 2-6
// - Port A low pins 2-6 reset undefined
// - Consecutive words from 0x070 to 0x090
// - Ports A, C, D high hold eight fields
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`include "pfsel_defines.vh"

module pfsel_top #(
  // Reset value of port A pins 2-6; only bits 27:8 are used
  parameter [31:0] PA_LOW_FLOAT = `PFSEL_PA_LOW_FLT
) (
  input  wire                                I_CLK,      // System clock
  input  wire                                I_SYS_RST,  // Sync reset, high
  input  wire [`PFSEL_AW-1:0]                I_ADDR,     // Byte address
  input  wire [`PFSEL_DW-1:0]                I_WDATA,    // Write data
  input  wire                                I_WR,       // Write strobe
  input  wire                                I_RD,       // Read strobe
  output reg  [`PFSEL_DW-1:0]                O_RDATA,    // Read data, next cycle
  output wire [`PFSEL_NPIN*`PFSEL_FW-1:0]    O_PIN_SEL,  // Code of every pin
  input  wire [`PFSEL_NPIN*`PFSEL_NFUNC-1:0] I_FUNC_OUT, // Function outputs
  input  wire [`PFSEL_NPIN*`PFSEL_NFUNC-1:0] I_FUNC_OE,  // Function enables
  input  wire [`PFSEL_NPIN-1:0]              I_PIN_IN,   // Pad input levels
  output wire [`PFSEL_NPIN-1:0]              O_PIN_OUT,  // Pad output levels
  output wire [`PFSEL_NPIN-1:0]              O_PIN_OE,   // Pad drive enables
  output wire [`PFSEL_NPIN*`PFSEL_NFUNC-1:0] O_FUNC_IN   // Pin level per function
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Full compare so aliases never hit a word,
  // and a misaligned byte address selects nothing
  function pfsel_hit;
    input [`PFSEL_AW-1:0] addr;
    input [`PFSEL_AW-1:0] ofs;
    begin
      pfsel_hit = (addr == ofs);
    end
  endfunction

  reg [`PFSEL_NREG-1:0] hit; // One-hot word select

  always @* begin
    hit = {`PFSEL_NREG{1'b0}};
    if (pfsel_hit(I_ADDR, `PFSEL_OFS_PA_LOW)) begin
      // Port A pins 0-7
      hit[0] = 1'b1;
    end else if (pfsel_hit(I_ADDR, `PFSEL_OFS_PA_HIGH)) begin
      // Port A pins 8-15
      hit[1] = 1'b1;
    end else if (pfsel_hit(I_ADDR, `PFSEL_OFS_PB_LOW)) begin
      // Port B pins 0-7
      hit[2] = 1'b1;
    end else if (pfsel_hit(I_ADDR, `PFSEL_OFS_PB_HIGH)) begin
      // Port B pins 8-13
      hit[3] = 1'b1;
    end else if (pfsel_hit(I_ADDR, `PFSEL_OFS_PC_LOW)) begin
      // Port C pins 0-7
      hit[4] = 1'b1;
    end else if (pfsel_hit(I_ADDR, `PFSEL_OFS_PC_HIGH)) begin
      // Port C pins 8-15
      hit[5] = 1'b1;
    end else if (pfsel_hit(I_ADDR, `PFSEL_OFS_PD_LOW)) begin
      // Port D pins 0-7
      hit[6] = 1'b1;
    end else if (pfsel_hit(I_ADDR, `PFSEL_OFS_PD_HIGH)) begin
      // Port D pins 8-15
      hit[7] = 1'b1;
    end else if (pfsel_hit(I_ADDR, `PFSEL_OFS_PE_LOW)) begin
      // Port E pins 0-7
      hit[8] = 1'b1;
    end else begin
      // Unmapped: no write lands, read returns zero
      hit = {`PFSEL_NREG{1'b0}};
    end
  end

  // Write enables per word
  wire [`PFSEL_NREG-1:0] we = hit & {`PFSEL_NREG{I_WR}};

  // ----------------------------------------------------------------------
  // Selection words
  // ----------------------------------------------------------------------
  // Each word feeds both the read mux and the pin code vector, so what
  // software reads back is exactly what steers the pads
  wire [31:0] port_a_low_function_select;  // Port A pins 0-7
  wire [31:0] port_a_high_function_select; // Port A pins 8-15
  wire [31:0] port_b_low_function_select;  // Port B pins 0-7
  wire [31:0] port_b_high_function_select; // Port B pins 8-13
  wire [31:0] port_c_low_function_select;  // Port C pins 0-7
  wire [31:0] port_c_high_function_select; // Port C pins 8-15
  wire [31:0] port_d_low_function_select;  // Port D pins 0-7
  wire [31:0] port_d_high_function_select; // Port D pins 8-15
  wire [31:0] port_e_low_function_select;  // Port E pins 0-7

  // A write lands at the edge that takes it and shows on O_PIN_SEL
  // at once; the pads follow one edge later through the routing flops.
  // Moving a pin between two functions therefore takes effect on the
  // pad one cycle after the write, never part-way through a cycle.

  // Pins 0, 1 and 7 forced zero; the middle is a build-time choice
  // since the silicon gives no fixed value there
  localparam [31:0] PA_LOW_RST = PA_LOW_FLOAT & ~`PFSEL_PA_LOW_FIX;

  pfsel_sel_reg #(
    .RESET_VAL (PA_LOW_RST),
    .IMPL_MASK (`PFSEL_MASK_FULL)
  ) u_pa_low (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_we    (we[0]),
    .i_wdata (I_WDATA),
    .o_value (port_a_low_function_select)
  );

  pfsel_sel_reg #(
    .RESET_VAL (`PFSEL_RST_ZERO),
    .IMPL_MASK (`PFSEL_MASK_FULL)
  ) u_pa_high (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_we    (we[1]),
    .i_wdata (I_WDATA),
    .o_value (port_a_high_function_select)
  );

  pfsel_sel_reg #(
    .RESET_VAL (`PFSEL_RST_ZERO),
    .IMPL_MASK (`PFSEL_MASK_FULL)
  ) u_pb_low (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_we    (we[2]),
    .i_wdata (I_WDATA),
    .o_value (port_b_low_function_select)
  );

  pfsel_sel_reg #(
    .RESET_VAL (`PFSEL_RST_ZERO),
    .IMPL_MASK (`PFSEL_MASK_PB_HI)
  ) u_pb_high (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_we    (we[3]),
    .i_wdata (I_WDATA),
    .o_value (port_b_high_function_select)
  );

  pfsel_sel_reg #(
    .RESET_VAL (`PFSEL_RST_ZERO),
    .IMPL_MASK (`PFSEL_MASK_FULL)
  ) u_pc_low (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_we    (we[4]),
    .i_wdata (I_WDATA),
    .o_value (port_c_low_function_select)
  );

  pfsel_sel_reg #(
    .RESET_VAL (`PFSEL_RST_ZERO),
    .IMPL_MASK (`PFSEL_MASK_FULL)
  ) u_pc_high (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_we    (we[5]),
    .i_wdata (I_WDATA),
    .o_value (port_c_high_function_select)
  );

  pfsel_sel_reg #(
    .RESET_VAL (`PFSEL_RST_ZERO),
    .IMPL_MASK (`PFSEL_MASK_FULL)
  ) u_pd_low (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_we    (we[6]),
    .i_wdata (I_WDATA),
    .o_value (port_d_low_function_select)
  );

  pfsel_sel_reg #(
    .RESET_VAL (`PFSEL_RST_ZERO),
    .IMPL_MASK (`PFSEL_MASK_FULL)
  ) u_pd_high (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_we    (we[7]),
    .i_wdata (I_WDATA),
    .o_value (port_d_high_function_select)
  );

  pfsel_sel_reg #(
    .RESET_VAL (`PFSEL_RST_ZERO),
    .IMPL_MASK (`PFSEL_MASK_FULL)
  ) u_pe_low (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_we    (we[8]),
    .i_wdata (I_WDATA),
    .o_value (port_e_low_function_select)
  );

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // The mux uses the same one-hot decode as the write enables, so a read
  // and a write to one address always agree on the word they touch.
  // Reserved port B bits need no mask here; the word never holds them.
  reg [`PFSEL_DW-1:0] next_rdata; // Word chosen by the address

  // Priority if-else chain over the one-hot hit; at most one branch can match
  always @* begin
    next_rdata = `PFSEL_RD_IDLE;
    if (hit[0]) begin
      next_rdata = port_a_low_function_select;
    end else if (hit[1]) begin
      next_rdata = port_a_high_function_select;
    end else if (hit[2]) begin
      next_rdata = port_b_low_function_select;
    end else if (hit[3]) begin
      next_rdata = port_b_high_function_select;
    end else if (hit[4]) begin
      next_rdata = port_c_low_function_select;
    end else if (hit[5]) begin
      next_rdata = port_c_high_function_select;
    end else if (hit[6]) begin
      next_rdata = port_d_low_function_select;
    end else if (hit[7]) begin
      next_rdata = port_d_high_function_select;
    end else if (hit[8]) begin
      next_rdata = port_e_low_function_select;
    end
  end

  // Data stand only in the cycle after the strobe; idle reads zero
  // so the bus can be OR-ed with other slaves without a select
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_RDATA <= `PFSEL_RD_IDLE;
    end else if (I_RD) begin
      O_RDATA <= next_rdata;
    end else begin
      O_RDATA <= `PFSEL_RD_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // Pin code vector
  // ----------------------------------------------------------------------
  // Pins in order A0-A15, B0-B13, C0-C15, D0-D15, E0-E7;
  // low word then high word
  assign O_PIN_SEL = {
    port_e_low_function_select,
    port_d_high_function_select,
    port_d_low_function_select,
    port_c_high_function_select,
    port_c_low_function_select,
    port_b_high_function_select[`PFSEL_PB_HIGH_W-1:0],
    port_b_low_function_select,
    port_a_high_function_select,
    port_a_low_function_select
  };

  // ----------------------------------------------------------------------
  // Per-pin routing
  // ----------------------------------------------------------------------
  // Registered routing adds one cycle from a write to the pad; a code
  // change therefore never glitches the pad within a cycle.
  // Limitation: a function sees its pad only while its code is chosen.
  genvar p;
  generate
    for (p = 0; p < `PFSEL_NPIN; p = p + 1) begin : g_pin
      pfsel_pin_route u_route (
        .i_clk      (I_CLK),
        .i_rst      (I_SYS_RST),
        .i_sel      (O_PIN_SEL[p*`PFSEL_FW +: `PFSEL_FW]),
        .i_func_out (I_FUNC_OUT[p*`PFSEL_NFUNC +: `PFSEL_NFUNC]),
        .i_func_oe  (I_FUNC_OE[p*`PFSEL_NFUNC +: `PFSEL_NFUNC]),
        .i_pin_in   (I_PIN_IN[p]),
        .o_pin_out  (O_PIN_OUT[p]),
        .o_pin_oe   (O_PIN_OE[p]),
        .o_func_in  (O_FUNC_IN[p*`PFSEL_NFUNC +: `PFSEL_NFUNC])
      );
    end
  endgenerate

endmodule // pfsel_top
